// *** logic/emi_ctrl.sv ***
// External memory interface: address decode, chip selects, wait states,
// bus width, paged windows and EDO DRAM control with APB registers.
// Assumes a processor on pclk and asynchronous external data pins.
`include "emi_params.svh"

module emi_ctrl
  import emi_pkg::*;
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [17:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Processor side
  input wire emi_cpu_req_t cpu_in,
  output logic cpu_ready,
  output logic [15:0] cpu_rdata,
  // Static memory pins
  output logic [21:0] ext_addr,
  output emi_sel_t ext_sel,
  input wire logic [15:0] ext_data_in,
  output logic [15:0] ext_data_out,
  output logic ext_data_oe_n,
  // DRAM pins
  output emi_dram_t dram
);

  // =============================================================
  // Functions
  function automatic emi_region_t region_of(input logic [15:0] a);
    if (a < `EMI_XRAM_LO) return RG_IRAM;
    else if (a < `EMI_PAGE1_LO) return RG_XRAM;
    else if (a < `EMI_PAGE2_LO) return RG_PAGE1;
    else if (a < `EMI_REGS_LO) return RG_PAGE2;
    else if (a < `EMI_XROM_LO) return RG_REGS;
    else if (a < `EMI_IROM_LO) return RG_XROM;
    else return RG_IROM;
  endfunction

  // Width flag above three wait bits
  function automatic logic [3:0] cfg_of(input emi_region_t r, input logic [15:0] x);
    if (r == RG_XRAM) return {x[`EMI_RA_W], x[`EMI_RA_WAIT +: 3]};
    else if (r == RG_XROM) return {x[`EMI_RO_W], x[`EMI_RO_WAIT +: 3]};
    else return {x[`EMI_EM_W], x[`EMI_EM_WAIT +: 3]};
  endfunction

  function automatic logic [15:0] wr16(input logic [15:0] old, input logic [31:0] d,
                                       input logic [3:0] s, input logic [15:0] m);
    logic [15:0] v;
    v = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
    return v & m;
  endfunction

  // =============================================================
  // Registers and state
  logic [15:0] page1_q, page2_q, dram_q, ext_q, imt_q;
  emi_state_t state_q, state_d;
  emi_region_t region_q, region_c;
  logic [2:0] wcnt_q, waits_q, acc_cyc_q;
  logic [1:0] scnt_q, be_q;
  logic ccnt_q, we_q, w8_q, int_q, dk_q, beat_q, pend_q, ready_q;
  logic row_open_q, rfsh_due_q;
  logic [9:0] open_row_q;
  logic [15:0] addr_q, wdata_q, rdata_q, din_s1_q, din_s2_q, dout_q, stat_c;
  logic [21:0] ext_addr_q;
  logic [9:0] dram_addr_q;
  logic [31:0] prdata_q;
  logic [10:0] rcnt_q;
  logic [19:0] dword_c;
  logic [3:0] cfg_c;
  logic is_dram_c, is_int_c, int_wait_c, row_hit_c, latch, done, beat_next;
  logic last_beat, static_act, apb_wr, apb_hit, page_win_q;

  // =============================================================
  // Request decode
  assign region_c = region_of(cpu_in.addr);
  assign cfg_c = cfg_of(region_c, ext_q);
  assign is_dram_c = (region_c == RG_PAGE1 && page1_q[`EMI_PG_DRAM]) ||
                     (region_c == RG_PAGE2 && page2_q[`EMI_PG_DRAM]);
  assign is_int_c = region_c == RG_IRAM || region_c == RG_REGS || region_c == RG_IROM;
  assign int_wait_c = (region_c == RG_IRAM && imt_q[`EMI_IMT_RA]) ||
                      (region_c == RG_IROM && imt_q[`EMI_IMT_RO]);
  assign dword_c = {(region_c == RG_PAGE1) ? page1_q[7:0] : page2_q[7:0],
                    cpu_in.addr[12:1]};
  assign row_hit_c = row_open_q && open_row_q == dword_c[19:10];
  assign last_beat = !w8_q || beat_q;
  assign page_win_q = region_q == RG_PAGE1 || region_q == RG_PAGE2;

  // =============================================================
  // Sequencer
  always_comb
  begin
    state_d = state_q;
    done = 1'b0;
    beat_next = 1'b0;
    latch = 1'b0;
    unique case (state_q)
      ST_IDLE:
        if (rfsh_due_q && dram_q[`EMI_RE])
          state_d = row_open_q ? ST_PRE : ST_RFC;
        else if (cpu_in.req && !ready_q)
        begin
          latch = 1'b1;
          if (is_dram_c)
          begin
            if (!row_open_q)
              state_d = ST_ROW;
            else if (row_hit_c && dram_q[`EMI_PE])
              state_d = ST_COL;
            else
              state_d = ST_PRE;
          end
          else if (is_int_c && !int_wait_c)
            done = 1'b1;
          else
            state_d = ST_ACC;
        end
      ST_ACC:
        if (wcnt_q == 3'h0)
        begin
          if (int_q)
            done = 1'b1;
          else if (!we_q)
            state_d = ST_SMP;
          else if (last_beat)
            done = 1'b1;
          else
            beat_next = 1'b1;
        end
      ST_SMP:
        if (scnt_q == 2'h0)
        begin
          if (last_beat || dk_q)
            done = 1'b1;
          else
            beat_next = 1'b1;
        end
      ST_ROW:
        state_d = ST_COL;
      ST_COL:
        if (ccnt_q == 1'b0)
        begin
          if (we_q)
            done = 1'b1;
          else
            state_d = ST_SMP;
        end
      ST_PRE:
        if (pend_q)
          state_d = ST_ROW;
        else if (rfsh_due_q && dram_q[`EMI_RE])
          state_d = ST_RFC;
        else
          state_d = ST_IDLE;
      ST_RFC:
        state_d = ST_RFR;
      ST_RFR:
        if (scnt_q == 2'h0)
          state_d = ST_IDLE;
    endcase
    if (done)
      state_d = (state_q != ST_IDLE && dk_q && !dram_q[`EMI_PE]) ? ST_PRE : ST_IDLE;
    if (beat_next)
      state_d = ST_ACC;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      state_q <= ST_IDLE;
    else
      state_q <= state_d;
  end

  // Latched access attributes
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      region_q <= RG_IRAM;
      we_q <= 1'b0;
      be_q <= 2'h0;
      w8_q <= 1'b0;
      waits_q <= 3'h0;
      int_q <= 1'b0;
      dk_q <= 1'b0;
      addr_q <= 16'h0000;
      wdata_q <= 16'h0000;
    end
    else if (latch)
    begin
      region_q <= region_c;
      we_q <= cpu_in.we;
      be_q <= cpu_in.be;
      w8_q <= cfg_c[3] && !is_dram_c;
      waits_q <= cfg_c[2:0];
      int_q <= is_int_c;
      dk_q <= is_dram_c;
      addr_q <= cpu_in.addr;
      wdata_q <= cpu_in.wdata;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      beat_q <= 1'b0;
      pend_q <= 1'b0;
      ready_q <= 1'b0;
    end
    else
    begin
      beat_q <= latch ? 1'b0 : (beat_next ? 1'b1 : beat_q);
      pend_q <= (latch && state_d == ST_PRE) ? 1'b1 : (state_q == ST_ROW ? 1'b0 : pend_q);
      ready_q <= done;
    end
  end

  // Wait, sample and column counters
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      wcnt_q <= 3'h0;
      scnt_q <= 2'h0;
      ccnt_q <= 1'b0;
    end
    else
    begin
      if (latch)
        wcnt_q <= is_int_c ? 3'h0 : cfg_c[2:0];
      else if (beat_next)
        wcnt_q <= waits_q;
      else if (state_q == ST_ACC && wcnt_q != 3'h0)
        wcnt_q <= wcnt_q - 3'h1;
      if (state_d == ST_SMP && state_q != ST_SMP)
        scnt_q <= 2'(`EMI_SYNC_CYC - 1);
      else if (state_d == ST_RFR && state_q != ST_RFR)
        scnt_q <= 2'(`EMI_RFR_CYC - 1);
      else if (scnt_q != 2'h0)
        scnt_q <= scnt_q - 2'h1;
      if (state_d == ST_COL && state_q != ST_COL)
        ccnt_q <= !dram_q[`EMI_DT];
      else
        ccnt_q <= 1'b0;
    end
  end

  // =============================================================
  // Data path
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      din_s1_q <= 16'h0000;
      din_s2_q <= 16'h0000;
    end
    else
    begin
      din_s1_q <= ext_data_in;
      din_s2_q <= din_s1_q;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      rdata_q <= 16'h0000;
    else if (state_q == ST_SMP && scnt_q == 2'h0)
    begin
      if (!w8_q)
        rdata_q <= din_s2_q;
      else if (!beat_q)
        rdata_q[7:0] <= din_s2_q[7:0];
      else
        rdata_q[15:8] <= din_s2_q[7:0];
    end
  end

  // Byte lane steering for 8-bit spaces, low byte first
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      dout_q <= 16'h0000;
    else if (latch)
      dout_q <= cpu_in.wdata;
    else if (beat_next)
      dout_q <= {8'h00, wdata_q[15:8]};
  end

  // External address: window pages, byte beats and address echo
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      ext_addr_q <= 22'h000000;
    else if (latch && region_c == RG_PAGE1)
      ext_addr_q <= {page1_q[8:0], cpu_in.addr[12:0]};
    else if (latch && region_c == RG_PAGE2)
      ext_addr_q <= {page2_q[8:0], cpu_in.addr[12:0]};
    else if (latch && !is_int_c)
      ext_addr_q <= {6'h00, cpu_in.addr};
    else if (beat_next)
      ext_addr_q[0] <= 1'b1;
    else if (state_q == ST_IDLE && imt_q[`EMI_IMT_DB])
      ext_addr_q <= {6'h00, cpu_in.addr};
  end

  // =============================================================
  // DRAM row tracking and refresh timer
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      row_open_q <= 1'b0;
      open_row_q <= 10'h000;
      dram_addr_q <= 10'h000;
    end
    else
    begin
      if (state_q == ST_PRE)
        row_open_q <= 1'b0;
      else if (state_q == ST_ROW)
        row_open_q <= 1'b1;
      if (latch && is_dram_c)
        open_row_q <= dword_c[19:10];
      if (latch && is_dram_c)
        dram_addr_q <= (state_d == ST_COL) ? dword_c[9:0] : dword_c[19:10];
      else if (state_q == ST_ROW)
        dram_addr_q <= addr_q[10:1];
    end
  end

  // A tick that lands on the clearing edge keeps the request pending
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      rcnt_q <= 11'h000;
      rfsh_due_q <= 1'b0;
    end
    else
    begin
      if (!dram_q[`EMI_RE] || rcnt_q == 11'(`EMI_RFSH_CYC - 1))
        rcnt_q <= 11'h000;
      else
        rcnt_q <= rcnt_q + 11'h001;
      rfsh_due_q <= (dram_q[`EMI_RE] && rcnt_q == 11'(`EMI_RFSH_CYC - 1)) ||
                    (rfsh_due_q && !(state_d == ST_RFC && state_q != ST_RFC));
    end
  end

  // =============================================================
  // Pins
  assign static_act = (state_q == ST_ACC || state_q == ST_SMP) && !int_q && !dk_q;
  assign ext_sel.ext_ram_select_n = !(static_act && region_q == RG_XRAM);
  assign ext_sel.paged_space_select_n = !(static_act && page_win_q);
  assign ext_sel.ext_rom_select_n = !(static_act && (region_q == RG_XROM ||
    (ext_q[`EMI_RM] && page_win_q)));
  assign ext_sel.rd_n = !(static_act && !we_q);
  assign ext_sel.wr_n = !(static_act && we_q && state_q == ST_ACC);
  assign ext_addr = ext_addr_q;
  assign ext_data_out = dout_q;
  assign ext_data_oe_n = !(we_q && ((static_act && state_q == ST_ACC) || state_q == ST_COL));
  assign cpu_ready = ready_q;
  assign cpu_rdata = rdata_q;

  // Page mode keeps the row strobe low between accesses
  assign dram.row_strobe_n = !((row_open_q && state_q != ST_PRE) ||
                               state_q == ST_ROW || state_q == ST_RFR);
  assign dram.column_strobe_low_n = !((state_q == ST_COL && be_q[0]) ||
                                      state_q == ST_RFC || state_q == ST_RFR);
  assign dram.column_strobe_high_n = !((state_q == ST_COL && be_q[1]) ||
                                       state_q == ST_RFC || state_q == ST_RFR);
  assign dram.dyn_write_strobe_n = !(state_q == ST_COL && we_q);
  assign dram.dyn_output_enable_n = !((state_q == ST_COL || state_q == ST_SMP) &&
                                      dk_q && !we_q);
  assign dram.addr = dram_addr_q;

  // =============================================================
  // APB registers
  assign stat_c = {11'h000, state_q, rfsh_due_q, row_open_q};
  assign apb_hit = paddr[17:2] == `EMI_IDX_PAGE1 || paddr[17:2] == `EMI_IDX_PAGE2 ||
                   paddr[17:2] == `EMI_IDX_DRAM || paddr[17:2] == `EMI_IDX_EXT ||
                   paddr[17:2] == `EMI_IDX_STAT || paddr[17:2] == `EMI_IDX_IMT;
  assign apb_wr = psel && penable && pwrite;
  assign pready = 1'b1;
  assign pslverr = psel && penable && !apb_hit;
  assign prdata = prdata_q;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      page1_q <= `EMI_RST_PAGE;
      page2_q <= `EMI_RST_PAGE;
      dram_q <= `EMI_RST_DRAM;
      ext_q <= `EMI_RST_EXT;
      imt_q <= `EMI_RST_IMT;
    end
    else if (apb_wr)
    begin
      if (paddr[17:2] == `EMI_IDX_PAGE1)
        page1_q <= wr16(page1_q, pwdata, pstrb, `EMI_MASK_PAGE);
      if (paddr[17:2] == `EMI_IDX_PAGE2)
        page2_q <= wr16(page2_q, pwdata, pstrb, `EMI_MASK_PAGE);
      if (paddr[17:2] == `EMI_IDX_DRAM)
        dram_q <= wr16(dram_q, pwdata, pstrb, `EMI_MASK_DRAM);
      if (paddr[17:2] == `EMI_IDX_EXT)
        ext_q <= wr16(ext_q, pwdata, pstrb, `EMI_MASK_EXT);
      if (paddr[17:2] == `EMI_IDX_IMT)
        imt_q <= wr16(imt_q, pwdata, pstrb, `EMI_MASK_IMT);
    end
  end

  // Read data is taken in the setup cycle so pready can stay high
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata_q <= 32'h00000000;
    else if (psel && !penable)
    begin
      unique case (paddr[17:2])
        `EMI_IDX_PAGE1: prdata_q <= {16'h0000, page1_q};
        `EMI_IDX_PAGE2: prdata_q <= {16'h0000, page2_q};
        `EMI_IDX_DRAM: prdata_q <= {16'h0000, dram_q};
        `EMI_IDX_EXT: prdata_q <= {16'h0000, ext_q};
        `EMI_IDX_STAT: prdata_q <= {16'h0000, stat_c};
        `EMI_IDX_IMT: prdata_q <= {16'h0000, imt_q};
        default: prdata_q <= 32'h00000000;
      endcase
    end
  end

  // =============================================================
  // Assertions
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      acc_cyc_q <= 3'h0;
    else
      acc_cyc_q <= (state_q == ST_ACC && state_d == ST_ACC && !beat_next) ?
                   acc_cyc_q + 3'h1 : 3'h0;
  end

  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  wait_len_a: assert property ((state_q == ST_ACC && wcnt_q == 3'h0 && !int_q && !beat_q)
    |-> acc_cyc_q == waits_q) else $error("wait state count wrong");
  reset_waits_a: assert property ($rose(presetn) |-> ext_q[2:0] == 3'h7)
    else $error("reset wait setting not seven");
  int_wait_a: assert property ((state_q == ST_ACC && int_q) |=> cpu_ready)
    else $error("internal wait not one cycle");
  page_one_a: assert property ((static_act && region_q == RG_PAGE1)
    |-> ext_addr[21:13] == page1_q[8:0]) else $error("page one bits wrong");
  page_two_a: assert property ((static_act && region_q == RG_PAGE2)
    |-> ext_addr[21:13] == page2_q[8:0]) else $error("page two bits wrong");
  dram_route_a: assert property ((state_q == ST_ROW) |-> dk_q && ext_sel.paged_space_select_n)
    else $error("dram cycle on static select");
  cbr_order_a: assert property ((state_q == ST_RFC) |-> !dram.column_strobe_low_n &&
    dram.row_strobe_n ##1 !dram.row_strobe_n && !dram.column_strobe_high_n)
    else $error("refresh strobe order wrong");
  short_col_a: assert property ((state_q == ST_COL && $past(state_q) != ST_COL &&
    dram_q[`EMI_DT]) |=> state_q != ST_COL) else $error("column phase not one clock");
  page_hit_a: assert property ((state_q == ST_IDLE && state_d == ST_COL) |-> row_open_q &&
    dram_q[`EMI_PE]) else $error("column cycle without open row");
  ram_sel_a: assert property ((static_act && region_q == RG_XRAM) |->
    !ext_sel.ext_ram_select_n && ext_sel.ext_rom_select_n) else $error("ram select wrong");
  rom_merge_a: assert property ((static_act && page_win_q) |->
    ext_sel.ext_rom_select_n == !ext_q[`EMI_RM]) else $error("rom merge select wrong");

  page_reuse_c: cover property (state_q == ST_IDLE && state_d == ST_COL);
  refresh_c: cover property (state_q == ST_RFC ##1 state_q == ST_RFR);
  byte_beat_c: cover property (beat_next ##[1:20] cpu_ready);

endmodule

// *** common/emi_params.svh ***
// Register map, field positions, reset values and timing counts of the
// external memory interface. Included by the design and the bench.
`ifndef EMI_PARAMS_SVH
`define EMI_PARAMS_SVH

// =============================================================
// Register indices (byte address is four times the index)
`define EMI_IDX_PAGE1 16'hc018
`define EMI_IDX_PAGE2 16'hc01a
`define EMI_IDX_DRAM 16'hc038
`define EMI_IDX_EXT 16'hc03a
`define EMI_IDX_STAT 16'hc03c
`define EMI_IDX_IMT 16'hc03e

// =============================================================
// Reset values and writable masks
`define EMI_RST_PAGE 16'h0000
`define EMI_RST_DRAM 16'h0000
`define EMI_RST_EXT 16'h0777
`define EMI_RST_IMT 16'h0000
`define EMI_MASK_PAGE 16'h01ff
`define EMI_MASK_DRAM 16'h0007
`define EMI_MASK_EXT 16'h1fff
`define EMI_MASK_IMT 16'h0007

// =============================================================
// Field positions
`define EMI_RM 12
`define EMI_EM_W 11
`define EMI_EM_WAIT 8
`define EMI_RO_W 7
`define EMI_RO_WAIT 4
`define EMI_RA_W 3
`define EMI_RA_WAIT 0
`define EMI_IMT_RA 2
`define EMI_IMT_RO 1
`define EMI_IMT_DB 0
`define EMI_DT 2
`define EMI_PE 1
`define EMI_RE 0
`define EMI_PG_DRAM 8

// =============================================================
// Address space boundaries
`define EMI_XRAM_LO 16'h0c00
`define EMI_PAGE1_LO 16'h8000
`define EMI_PAGE2_LO 16'ha000
`define EMI_REGS_LO 16'hc000
`define EMI_XROM_LO 16'hc100
`define EMI_IROM_LO 16'he800

// =============================================================
// Timing
`define EMI_CLK_NS 10
`define EMI_RFSH_NS 15600
`define EMI_RFSH_CYC (`EMI_RFSH_NS / `EMI_CLK_NS)
`define EMI_SYNC_CYC 2
`define EMI_RFR_CYC 2

`endif

// *** common/emi_pkg.sv ***
// Types shared by the external memory interface and its bench.
// Assumes emi_params.svh is on the include path.
package emi_pkg;

  typedef enum logic [2:0]
  {
    ST_IDLE = 3'b000,
    ST_ACC = 3'b001,
    ST_SMP = 3'b011,
    ST_ROW = 3'b010,
    ST_COL = 3'b110,
    ST_PRE = 3'b111,
    ST_RFC = 3'b101,
    ST_RFR = 3'b100
  } emi_state_t;

  typedef enum logic [2:0]
  {
    RG_IRAM, RG_XRAM, RG_PAGE1, RG_PAGE2, RG_REGS, RG_XROM, RG_IROM
  } emi_region_t;

  // Processor request, held until cpu_ready
  typedef struct packed {
    logic req;
    logic we;
    logic [1:0] be;
    logic [15:0] addr;
    logic [15:0] wdata;
  } emi_cpu_req_t;

  typedef struct packed {
    logic ext_ram_select_n;
    logic ext_rom_select_n;
    logic paged_space_select_n;
    logic rd_n;
    logic wr_n;
  } emi_sel_t;

  typedef struct packed {
    logic row_strobe_n;
    logic column_strobe_low_n;
    logic column_strobe_high_n;
    logic dyn_write_strobe_n;
    logic dyn_output_enable_n;
    logic [9:0] addr;
  } emi_dram_t;

endpackage

// *** bench/emi_mem_model.sv ***
// Static memory and EDO DRAM chips seen on the far side of the external pins.
// Assumes selects and strobes are sampled on pclk.
module emi_mem_model
  import emi_pkg::*;
(
  // Clock
  input wire logic pclk,
  // Pins from the block
  input wire emi_sel_t sel,
  input wire logic [21:0] addr,
  // DRAM pins from the block
  input wire emi_dram_t dram,
  // Data towards the block
  output logic [15:0] data
);
  timeunit 1ns;
  timeprecision 1ps;
  logic hit;
  assign hit = !sel.ext_ram_select_n || !sel.ext_rom_select_n || !sel.paged_space_select_n;
  logic [15:0] sd;
  initial sd = 16'h0000;
  // =============================================================
  // Read data
  // EDO parts drive while output enable is low, with no register delay
  assign data = !dram.dyn_output_enable_n ? ({6'h00, dram.addr} ^ 16'h3c5a) : sd;
  // Static parts answer one clock late; released bus toggles so a late
  // sample never matches by chance
  always @(posedge pclk)
  begin
    sd <= (hit && !sel.rd_n) ? (addr[15:0] ^ 16'ha5c3) : ~sd;
  end
endmodule

// *** bench/tb_external_memory_interface.sv ***
// Bench for the external memory interface: APB register and processor tests.
// Assumes emi_params.svh on the include path and emi_pkg compiled first.
`include "emi_params.svh"
`define CHK(n, e, a) begin checked++; if ((a) !== (e)) begin miscompares++; \
  $display("BAD %s exp %h got %h", n, e, a); end end
module tb_external_memory_interface
  import emi_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [17:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, r;
  logic [3:0] pstrb = 4'hf;
  logic pready, pslverr, err, cpu_ready;
  emi_cpu_req_t cpu_in = '0;
  logic [15:0] cpu_rdata, ext_data_in, ext_data_out;
  logic [21:0] ext_addr;
  emi_sel_t ext_sel;
  emi_dram_t dram;
  logic ext_data_oe_n;
  logic [2:0] lo;
  logic [8:0] pg;
  logic [15:0] wd;
  int miscompares = 0, checked = 0, cyc = 0, n, rf = 0;
  always #5 pclk = ~pclk;
  emi_ctrl emi_ctrl_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .cpu_in(cpu_in), .cpu_ready(cpu_ready),
    .cpu_rdata(cpu_rdata), .ext_addr(ext_addr), .ext_sel(ext_sel),
    .ext_data_in(ext_data_in), .ext_data_out(ext_data_out),
    .ext_data_oe_n(ext_data_oe_n), .dram(dram));
  emi_mem_model emi_mem_model_i (.pclk(pclk), .sel(ext_sel), .addr(ext_addr),
    .dram(dram), .data(ext_data_in));
  // =============================================================
  // Select monitor and hang guard
  always @(posedge pclk)
  begin
    cyc++;
    if (cpu_in.req)
      lo <= lo & {ext_sel.ext_ram_select_n, ext_sel.ext_rom_select_n,
        ext_sel.paged_space_select_n};
    if (!ext_sel.paged_space_select_n)
      pg <= ext_addr[21:13];
    if (!ext_sel.wr_n && !ext_data_oe_n)
      wd <= ext_data_out;
    // Column strobe low with row strobe high only happens in refresh
    if (!dram.column_strobe_low_n && dram.row_strobe_n)
      rf <= rf + 1;
    if (cyc == 20000)
    begin
      miscompares++;
      complete_run();
    end
  end
  task automatic complete_run();
    if (miscompares == 0 && checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // =============================================================
  // Bus tasks
  task automatic apb(input logic w, input logic [15:0] idx, input logic [15:0] d);
    psel <= 1;
    pwrite <= w;
    paddr <= {idx, 2'b00};
    pwdata <= {16'h0000, d};
    @(posedge pclk);
    penable <= 1;
    do @(posedge pclk); while (pready !== 1'b1);
    r = prdata;
    err = pslverr;
    psel <= 0;
    penable <= 0;
    @(posedge pclk);
  endtask
  task automatic cpu(input logic [15:0] a, input logic w = 1'b0,
                     input logic [15:0] d = 16'h0000);
    lo <= 3'b111;
    cpu_in <= '{req: 1'b1, we: w, be: 2'b11, addr: a, wdata: d};
    n = 0;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (cpu_ready !== 1'b1);
    cpu_in.req <= 0;
    @(posedge pclk);
  endtask
  // =============================================================
  // Tests
  logic [15:0] idx[5] = '{16'hc018, 16'hc01a, 16'hc038, 16'hc03a, 16'hc03e};
  logic [15:0] rst[5] = '{16'h0000, 16'h0000, 16'h0000, 16'h0777, 16'h0000};
  initial
  begin
    repeat (20) @(posedge pclk);
    presetn <= 1;
    @(posedge pclk);
    foreach (idx[i])
    begin
      apb(0, idx[i], 0);
      `CHK("reset value", {16'h0000, rst[i]}, r)
    end
    apb(0, 16'hc000, 0);
    `CHK("unmapped error", 1'b1, err)
    apb(1, 16'hc018, 16'hffff);
    apb(0, 16'hc018, 0);
    `CHK("page reserved", 32'h000001ff, r)
    cpu(16'h0c00);
    `CHK("ram read cycles", 12, n)
    `CHK("ram select", 3'b011, lo)
    `CHK("ram data", 16'h0c00 ^ 16'ha5c3, cpu_rdata)
    cpu(16'h0100);
    `CHK("iram cycles", 2, n)
    `CHK("iram selects", 3'b111, lo)
    apb(1, 16'hc03e, 16'h0004);
    cpu(16'h0100);
    `CHK("iram wait cycles", 3, n)
    apb(1, 16'hc018, 16'h0055);
    cpu(16'h8000);
    `CHK("page one select", 3'b110, lo)
    `CHK("page one bits", 9'h055, pg)
    apb(1, 16'hc01a, 16'h00aa);
    cpu(16'ha000);
    `CHK("page two bits", 9'h0aa, pg)
    apb(1, 16'hc03a, 16'h1111);
    cpu(16'hc100);
    `CHK("rom select", 3'b101, lo)
    cpu(16'h8000);
    `CHK("merge select", 3'b100, lo)
    apb(1, 16'hc03a, 16'h1191);
    cpu(16'hc100);
    `CHK("rom byte cycles", 10, n)
    `CHK("rom byte data", 16'hc2c3, cpu_rdata)
    cpu(16'h0c02, 1'b1, 16'h1234);
    `CHK("ram write cycles", 4, n)
    `CHK("ram write data", 16'h1234, wd)
    apb(1, 16'hc03e, 16'h0003);
    cpu(16'he800);
    `CHK("irom wait cycles", 3, n)
    `CHK("echo address", 22'h00e800, ext_addr)
    apb(1, 16'hc018, 16'h0101);
    apb(1, 16'hc038, 16'h0002);
    cpu(16'h8002);
    `CHK("dram miss cycles", 7, n)
    `CHK("dram selects", 3'b111, lo)
    `CHK("dram data", 16'h3c5b, cpu_rdata)
    apb(1, 16'hc038, 16'h0006);
    cpu(16'h8004);
    `CHK("dram hit cycles", 5, n)
    `CHK("dram hit data", 16'h3c58, cpu_rdata)
    apb(1, 16'hc038, 16'h0007);
    repeat (1600) @(posedge pclk);
    `CHK("refresh count", 1, rf)
    complete_run();
  end
endmodule
